// ===== rtl/ptpc_consts.svh
// Constants of the port tag and line control register bank.
// Assumes inclusion by bare name from the bank and its boot loader.
`ifndef PTPC_CONSTS_SVH
`define PTPC_CONSTS_SVH

// Management register offsets
`define PTPC_REG_TAG1 5'h19
`define PTPC_REG_TAG4 5'h1c
`define PTPC_REG_CTL 5'h1d

// Management frame codes
`define PTPC_OP_READ 2'h2
`define PTPC_OP_WRITE 2'h1
`define PTPC_PREAMBLE_LEN 6'h20
`define PTPC_HDR_LAST 6'h0b
`define PTPC_DATA_LAST 6'h0f

// Line control field positions
`define PTPC_BIT_JAB 10
`define PTPC_BIT_HB 9
`define PTPC_BIT_REP 8
`define PTPC_BIT_FIX 5
`define PTPC_ADDR_HI 4
`define PTPC_RSVD_HI 4'h0
`define PTPC_RSVD_ONE 1'b1

// Reset values
`define PTPC_TAG_RST 16'h0000
`define PTPC_JAB_RST 1'b0
`define PTPC_HB_RST 1'b0
`define PTPC_REP_RST 1'b1
`define PTPC_FIX_RST 1'b0
`define PTPC_ADDR_RST 5'h00

// EEPROM layout
`define PTPC_EE_SIG0 8'h00
`define PTPC_EE_SIG1 8'h01
`define PTPC_EE_T1_LO 8'h1a
`define PTPC_EE_T1_HI 8'h1b
`define PTPC_EE_T2_LO 8'h1c
`define PTPC_EE_T2_HI 8'h1d
`define PTPC_EE_T3_LO 8'h1e
`define PTPC_EE_T4_LO 8'h20
`define PTPC_EE_T4_HI 8'h21
`define PTPC_EE_PAT0 8'h55
`define PTPC_EE_PAT1 8'haa
`define PTPC_EE_LAST_IDX 4'h8

`endif

// ===== rtl/ptpc_eeprom_load.sv
// Boot loader: reads tag defaults from a byte-wide EEPROM read port.
// Assumes the read port answers each held request with a one-cycle ack.
`timescale 1ns/100ps
`include "ptpc_consts.svh"
module ptpc_eeprom_load
   import ptpc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   output ptpc_ee_req_t ee_req,
   input wire logic [7:0] ee_rd_data,
   input wire logic ee_rd_ack,
   output logic load_pulse,
   output logic busy,
   output ptpc_tags_t load_tags
);
   localparam int NBYTES = 9;

   ptpc_ld_state_t state_q, state_d;
   logic [3:0] idx_q, idx_d;
   logic [7:0] byte_q [NBYTES];
   logic [7:0] byte_d [NBYTES];
   logic req_q, req_d;
   logic load_q, load_d;

   function automatic logic [7:0] addr_of(input logic [3:0] idx);
      case (idx)
         4'h0: addr_of = `PTPC_EE_SIG0;
         4'h1: addr_of = `PTPC_EE_SIG1;
         4'h2: addr_of = `PTPC_EE_T1_LO;
         4'h3: addr_of = `PTPC_EE_T1_HI;
         4'h4: addr_of = `PTPC_EE_T2_LO;
         4'h5: addr_of = `PTPC_EE_T2_HI;
         4'h6: addr_of = `PTPC_EE_T3_LO;
         4'h7: addr_of = `PTPC_EE_T4_LO;
         default: addr_of = `PTPC_EE_T4_HI;
      endcase
   endfunction

   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      byte_d = byte_q;
      req_d = req_q;
      load_d = 1'b0;
      case (state_q)
         PTPC_LD_REQ: begin
            req_d = 1'b1;
            if (req_q && ee_rd_ack) begin
               req_d = 1'b0;
               byte_d[idx_q] = ee_rd_data;
               if (idx_q == 4'h1 && (byte_q[0] != `PTPC_EE_PAT0 ||
                                     ee_rd_data != `PTPC_EE_PAT1)) begin
                  state_d = PTPC_LD_DONE;
               end else if (idx_q == `PTPC_EE_LAST_IDX) begin
                  state_d = PTPC_LD_DONE;
                  load_d = 1'b1;
               end else begin
                  idx_d = idx_q + 4'h1;
                  state_d = PTPC_LD_GAP;
               end
            end
         end
         PTPC_LD_GAP: begin
            state_d = PTPC_LD_REQ;
         end
         PTPC_LD_DONE: begin
            req_d = 1'b0;
         end
         default: begin
            state_d = PTPC_LD_DONE;
            req_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_q <= PTPC_LD_REQ;
         idx_q <= 4'h0;
         req_q <= 1'b0;
         load_q <= 1'b0;
         for (int i = 0; i < NBYTES; i++) begin
            byte_q[i] <= 8'h00;
         end
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         req_q <= req_d;
         load_q <= load_d;
         byte_q <= byte_d;
      end
   end

   assign ee_req.rd_req = req_q;
   assign ee_req.rd_addr = addr_of(idx_q);
   assign load_pulse = load_q;
   assign busy = (state_q != PTPC_LD_DONE);
   // Port 3 high byte has no EEPROM home; the bank skips it on load
   assign load_tags[0] = {byte_q[3], byte_q[2]};
   assign load_tags[1] = {byte_q[5], byte_q[4]};
   assign load_tags[2] = {8'h00, byte_q[6]};
   assign load_tags[3] = {byte_q[8], byte_q[7]};
endmodule

// ===== rtl/ptpc_pkg.sv
// Types shared by the port tag register bank and its boot loader.
// Assumes nothing beyond a SystemVerilog compiler.
package ptpc_pkg;

   typedef logic [3:0][15:0] ptpc_tags_t;

   typedef struct packed {
      logic jabber_en;
      logic heartbeat_en;
      logic repeater_mode;
      logic addr_match_en;
      logic [4:0] phy_addr;
   } ptpc_ctl_t;

   typedef struct packed {
      logic rd_req;
      logic [7:0] rd_addr;
   } ptpc_ee_req_t;

   typedef enum logic [2:0] {
      PTPC_SMI_IDLE = 3'b000,
      PTPC_SMI_START = 3'b001,
      PTPC_SMI_HDR = 3'b010,
      PTPC_SMI_TA = 3'b011,
      PTPC_SMI_DATA = 3'b100
   } ptpc_smi_state_t;

   typedef enum logic [1:0] {
      PTPC_LD_REQ = 2'b00,
      PTPC_LD_GAP = 2'b01,
      PTPC_LD_DONE = 2'b10
   } ptpc_ld_state_t;

endpackage

// ===== rtl/ptpc_regs.sv
// Port tag and line control register bank behind a serial management slave.
// Assumes mdc_i and mdio_i already synchronous to clk_sys, MDC well below it.
`timescale 1ns/100ps
`include "ptpc_consts.svh"
module ptpc_regs
   import ptpc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   input wire logic partner_autoneg_capable,
   input wire logic rx_polarity_reversed,
   output logic ee_rd_req,
   output logic [7:0] ee_rd_addr,
   input wire logic [7:0] ee_rd_data,
   input wire logic ee_rd_ack,
   output logic init_busy,
   output ptpc_tags_t tag_value,
   output logic jabber_en,
   output logic heartbeat_en,
   output logic repeater_mode
);
   ptpc_ee_req_t ee_req;
   logic ee_load;
   logic ee_busy;
   ptpc_tags_t ee_tags;

   ptpc_eeprom_load ptpc_eeprom_load_i (
      .clk_sys(clk_sys),
      .srst(srst),
      .ee_req(ee_req),
      .ee_rd_data(ee_rd_data),
      .ee_rd_ack(ee_rd_ack),
      .load_pulse(ee_load),
      .busy(ee_busy),
      .load_tags(ee_tags)
   );

   // Frame engine state
   ptpc_smi_state_t st_q, st_d;
   logic [5:0] cnt_q, cnt_d;
   logic [11:0] hdr_q, hdr_d;
   logic [15:0] sh_q, sh_d;
   logic rd_q, rd_d;
   logic hit_q, hit_d;
   logic mdc_last_q, mdc_last_d;
   logic oe_q, oe_d;
   logic out_q, out_d;
   logic wr_stb;
   logic [4:0] wr_reg;

   // Register state
   ptpc_tags_t tag_q, tag_d;
   ptpc_ctl_t ctl_q, ctl_d;
   logic lp_q, lp_d;
   logic pol_q, pol_d;
   logic req_q, req_d;
   logic [7:0] addr_q, addr_d;
   logic busy_q, busy_d;

   logic mdc_rise;
   logic [15:0] ctl_rd;
   logic [15:0] rd_val;

   assign mdc_rise = mdc_i & ~mdc_last_q;

   // Reserved bits are constants, status bits come from the samplers
   assign ctl_rd = {`PTPC_RSVD_HI, `PTPC_RSVD_ONE, ctl_q.jabber_en, ctl_q.heartbeat_en,
                    ctl_q.repeater_mode, lp_q, pol_q, ctl_q.addr_match_en,
                    ctl_q.phy_addr};

   always_comb begin
      rd_val = ctl_rd;
      if (hdr_q[4:0] != `PTPC_REG_CTL) begin
         rd_val = tag_q[hdr_q[1:0] - 2'h1];
      end
   end

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      hdr_d = hdr_q;
      sh_d = sh_q;
      rd_d = rd_q;
      hit_d = hit_q;
      mdc_last_d = mdc_i;
      oe_d = oe_q;
      out_d = out_q;
      wr_stb = 1'b0;
      wr_reg = hdr_q[4:0];
      if (mdc_rise) begin
         case (st_q)
            PTPC_SMI_IDLE: begin
               if (mdio_i) begin
                  if (cnt_q != `PTPC_PREAMBLE_LEN) begin
                     cnt_d = cnt_q + 6'h01;
                  end
               end else begin
                  if (cnt_q == `PTPC_PREAMBLE_LEN) begin
                     st_d = PTPC_SMI_START;
                  end
                  cnt_d = 6'h00;
               end
            end
            PTPC_SMI_START: begin
               st_d = mdio_i ? PTPC_SMI_HDR : PTPC_SMI_IDLE;
               cnt_d = 6'h00;
            end
            PTPC_SMI_HDR: begin
               hdr_d = {hdr_q[10:0], mdio_i};
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == `PTPC_HDR_LAST) begin
                  cnt_d = 6'h00;
                  rd_d = (hdr_d[11:10] == `PTPC_OP_READ);
                  hit_d = (!ctl_q.addr_match_en ||
                           hdr_d[9:5] == ctl_q.phy_addr) &&
                          hdr_d[4:0] >= `PTPC_REG_TAG1 &&
                          hdr_d[4:0] <= `PTPC_REG_CTL;
                  if (hdr_d[11:10] == `PTPC_OP_READ || hdr_d[11:10] == `PTPC_OP_WRITE) begin
                     st_d = PTPC_SMI_TA;
                  end else begin
                     st_d = PTPC_SMI_IDLE;
                  end
               end
            end
            PTPC_SMI_TA: begin
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == 6'h00) begin
                  // Drive the second turnaround bit low
                  oe_d = rd_q && hit_q;
                  out_d = 1'b0;
                  sh_d = rd_val;
               end else begin
                  out_d = sh_q[15];
                  sh_d = {sh_q[14:0], 1'b0};
                  st_d = PTPC_SMI_DATA;
                  cnt_d = 6'h00;
               end
            end
            PTPC_SMI_DATA: begin
               cnt_d = cnt_q + 6'h01;
               if (rd_q) begin
                  out_d = sh_q[15];
                  sh_d = {sh_q[14:0], 1'b0};
               end else begin
                  sh_d = {sh_q[14:0], mdio_i};
               end
               if (cnt_q == `PTPC_DATA_LAST) begin
                  oe_d = 1'b0;
                  out_d = 1'b0;
                  wr_stb = !rd_q && hit_q;
                  st_d = PTPC_SMI_IDLE;
                  cnt_d = 6'h00;
               end
            end
            default: begin
               st_d = PTPC_SMI_IDLE;
               cnt_d = 6'h00;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_q <= PTPC_SMI_IDLE;
         cnt_q <= 6'h00;
         hdr_q <= 12'h000;
         sh_q <= 16'h0000;
         rd_q <= 1'b0;
         hit_q <= 1'b0;
         mdc_last_q <= 1'b0;
         oe_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         hdr_q <= hdr_d;
         sh_q <= sh_d;
         rd_q <= rd_d;
         hit_q <= hit_d;
         mdc_last_q <= mdc_last_d;
         oe_q <= oe_d;
         out_q <= out_d;
      end
   end

   // Register file; a boot load in the same cycle as a write wins, except on the port 3 high byte
   always_comb begin
      tag_d = tag_q;
      ctl_d = ctl_q;
      lp_d = partner_autoneg_capable;
      pol_d = rx_polarity_reversed;
      req_d = ee_req.rd_req;
      addr_d = ee_req.rd_addr;
      busy_d = ee_busy;
      if (wr_stb) begin
         if (wr_reg == `PTPC_REG_CTL) begin
            // Bits 15:11 and 7:6 are not stored
            ctl_d.jabber_en = sh_d[`PTPC_BIT_JAB];
            ctl_d.heartbeat_en = sh_d[`PTPC_BIT_HB];
            ctl_d.repeater_mode = sh_d[`PTPC_BIT_REP];
            ctl_d.addr_match_en = sh_d[`PTPC_BIT_FIX];
            ctl_d.phy_addr = sh_d[`PTPC_ADDR_HI:0];
         end else begin
            tag_d[wr_reg[1:0] - 2'h1] = sh_d;
         end
      end
      if (ee_load) begin
         for (int p = 0; p < 4; p++) begin
            tag_d[p][7:0] = ee_tags[p][7:0];
            if (p != 2) begin
               tag_d[p][15:8] = ee_tags[p][15:8];
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int p = 0; p < 4; p++) begin
            tag_q[p] <= `PTPC_TAG_RST;
         end
         ctl_q.jabber_en <= `PTPC_JAB_RST;
         ctl_q.heartbeat_en <= `PTPC_HB_RST;
         ctl_q.repeater_mode <= `PTPC_REP_RST;
         ctl_q.addr_match_en <= `PTPC_FIX_RST;
         ctl_q.phy_addr <= `PTPC_ADDR_RST;
         lp_q <= 1'b0;
         pol_q <= 1'b0;
         req_q <= 1'b0;
         addr_q <= 8'h00;
         busy_q <= 1'b1;
      end else begin
         tag_q <= tag_d;
         ctl_q <= ctl_d;
         lp_q <= lp_d;
         pol_q <= pol_d;
         req_q <= req_d;
         addr_q <= addr_d;
         busy_q <= busy_d;
      end
   end

   assign mdio_o = out_q;
   assign mdio_oe = oe_q;
   assign ee_rd_req = req_q;
   assign ee_rd_addr = addr_q;
   assign init_busy = busy_q;
   assign tag_value = tag_q;
   assign jabber_en = ctl_q.jabber_en;
   assign heartbeat_en = ctl_q.heartbeat_en;
   assign repeater_mode = ctl_q.repeater_mode;
endmodule

// ===== verif/ptpc_far_end.sv
// Far side model: management master and boot EEPROM read port.
// Assumes mdio_w is the resolved line, pulled up when idle.
`timescale 1ns/100ps
module ptpc_far_end (
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic mdio_w,
   output logic mdc,
   output logic m_d,
   output logic m_oe,
   input wire logic ee_rd_req,
   input wire logic [7:0] ee_rd_addr,
   output logic [7:0] ee_rd_data,
   output logic ee_rd_ack
);
   logic [7:0] rom [256];
   logic done;
   int wt;
   initial begin
      mdc = 1'b0;
      m_d = 1'b1;
      m_oe = 1'b0;
      ee_rd_ack = 1'b0;
      ee_rd_data = 8'h00;
      done = 1'b0;
      wt = 0;
      for (int i = 0; i < 256; i++) rom[i] = 8'(i * 7 + 3);
      rom[0] = 8'h55;
      rom[1] = 8'haa;
   end
   // One ack per request; data toggles when not valid
   always @(negedge clk_sys) begin
      ee_rd_ack <= 1'b0;
      ee_rd_data <= ~ee_rd_data;
      if (!ee_rd_req) begin
         done <= 1'b0;
         wt <= slow ? 3 : 0;
      end else if (!done && wt > 0) begin
         wt <= wt - 1;
      end else if (!done) begin
         ee_rd_ack <= 1'b1;
         ee_rd_data <= rom[ee_rd_addr];
         done <= 1'b1;
      end
   end
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
         input logic [15:0] wd, output logic [15:0] q);
      logic [63:0] sh;
      sh = {32'hffff_ffff, 2'b01, op, pa, ra, 2'b10, wd};
      q = 16'h0000;
      for (int i = 0; i < 64; i++) begin
         @(negedge clk_sys);
         mdc <= 1'b0;
         m_d <= sh[63 - i];
         // Line let go from turnaround on reads
         m_oe <= !(op == 2'h2 && i > 45);
         repeat (2) @(negedge clk_sys);
         if (i > 47) q = {q[14:0], mdio_w};
         mdc <= 1'b1;
         @(negedge clk_sys);
      end
      repeat (2) @(negedge clk_sys);
      mdc <= 1'b0;
      m_oe <= 1'b0;
   endtask
endmodule

// ===== verif/ptpc_regs_sva.sv
// Port checker of the tag register bank.
// Assumes it is bound to ptpc_regs, one clock domain.
`timescale 1ns/100ps
module ptpc_regs_sva
   import ptpc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic mdc_i,
   input wire logic mdio_o,
   input wire logic mdio_oe,
   input wire logic ee_rd_req,
   input wire logic [7:0] ee_rd_addr,
   input wire logic [7:0] ee_rd_data,
   input wire logic ee_rd_ack,
   input wire logic init_busy,
   input wire ptpc_tags_t tag_value,
   input wire logic jabber_en,
   input wire logic heartbeat_en,
   input wire logic repeater_mode
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic [7:0] ee_q, ee_d;
   // Last boot byte, kept because the tag lands two cycles later
   always_comb ee_d = ee_rd_ack ? ee_rd_data : ee_q;
   always_ff @(posedge clk_sys) ee_q <= ee_d;
   property p_rst;
      disable iff (1'b0) srst |=> tag_value == '0 && !jabber_en && !heartbeat_en &&
         repeater_mode && !mdio_oe && init_busy && !ee_rd_req;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_boot_go;
      $fell(srst) |-> ##[1:4] ee_rd_req && ee_rd_addr == 8'h00;
   endproperty
   a_boot_go: assert property (p_boot_go) else $error("no boot read");
   property p_req_drop;
      ee_rd_ack |-> ##[1:3] !ee_rd_req;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("read held");
   property p_boot_end;
      ee_rd_ack && ee_rd_addr == 8'h21 |-> ##[2:3] !init_busy && tag_value[3][15:8] == ee_q;
   endproperty
   a_boot_end: assert property (p_boot_end) else $error("boot end wrong");
   property p_bad_sig;
      ee_rd_ack && ee_rd_addr == 8'h01 && ee_rd_data != 8'haa |-> ##[1:8] !init_busy;
   endproperty
   a_bad_sig: assert property (p_bad_sig) else $error("boot not stopped");
   property p_ta_low;
      $rose(mdio_oe) |-> (!mdio_o && mdio_oe) [*4];
   endproperty
   a_ta_low: assert property (p_ta_low) else $error("bad turnaround");
   property p_bit_step;
      mdio_oe && $changed(mdio_o) |-> $past(mdc_i);
   endproperty
   a_bit_step: assert property (p_bit_step) else $error("data off mdc");
   property p_ctl_step;
      $changed({jabber_en, heartbeat_en, repeater_mode}) |-> $past(mdc_i);
   endproperty
   a_ctl_step: assert property (p_ctl_step) else $error("ctl moved");
   property p_tag_step;
      $changed(tag_value) |-> $past(mdc_i) || $past(init_busy);
   endproperty
   a_tag_step: assert property (p_tag_step) else $error("tag moved");
   c_boot: cover property ($fell(init_busy));
   c_read: cover property ($rose(mdio_oe));
   c_ctl: cover property ($rose(jabber_en));
endmodule
bind ptpc_regs ptpc_regs_sva ptpc_regs_sva_i (.clk_sys(clk_sys), .srst(srst),
   .mdc_i(mdc_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .ee_rd_req(ee_rd_req),
   .ee_rd_addr(ee_rd_addr), .ee_rd_data(ee_rd_data), .ee_rd_ack(ee_rd_ack),
   .init_busy(init_busy), .tag_value(tag_value), .jabber_en(jabber_en),
   .heartbeat_en(heartbeat_en), .repeater_mode(repeater_mode));

// ===== verif/ptpc_regs_tb.sv
// Self-checking bench of the tag register bank.
// Assumes the far end model and the bound checker.
`timescale 1ns/100ps
module ptpc_regs_tb
   import ptpc_pkg::*;
;
   logic clk_sys, srst, mdc_i, mdio_i, mdio_o, mdio_oe, m_d, m_oe, slow;
   logic partner_autoneg_capable, rx_polarity_reversed, ee_rd_req, ee_rd_ack;
   logic init_busy, jabber_en, heartbeat_en, repeater_mode;
   logic [7:0] ee_rd_addr, ee_rd_data;
   ptpc_tags_t tag_value;
   logic [15:0] v;
   int err_total, checked;
   assign mdio_i = mdio_oe ? mdio_o : (m_oe ? m_d : 1'b1);
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   ptpc_regs ptpc_regs_i (.clk_sys(clk_sys), .srst(srst), .mdc_i(mdc_i), .mdio_i(mdio_i),
      .mdio_o(mdio_o), .mdio_oe(mdio_oe), .partner_autoneg_capable(partner_autoneg_capable),
      .rx_polarity_reversed(rx_polarity_reversed), .ee_rd_req(ee_rd_req),
      .ee_rd_addr(ee_rd_addr), .ee_rd_data(ee_rd_data), .ee_rd_ack(ee_rd_ack),
      .init_busy(init_busy), .tag_value(tag_value), .jabber_en(jabber_en),
      .heartbeat_en(heartbeat_en), .repeater_mode(repeater_mode));
   ptpc_far_end ptpc_far_end_i (.clk_sys(clk_sys), .slow(slow), .mdio_w(mdio_i),
      .mdc(mdc_i), .m_d(m_d), .m_oe(m_oe), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
      .ee_rd_data(ee_rd_data), .ee_rd_ack(ee_rd_ack));
   function automatic logic [7:0] eb(input int a);
      return 8'(a * 7 + 3);
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
      ptpc_far_end_i.frame(2'h1, pa, ra, d, v);
   endtask
   task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
      ptpc_far_end_i.frame(2'h2, pa, ra, 16'h0000, v);
      chk(v, e);
   endtask
   task automatic do_reset();
      srst <= 1'b1;
      repeat (8) @(negedge clk_sys);
      srst <= 1'b0;
   endtask
   task automatic wait_boot();
      int n;
      n = 0;
      while (init_busy !== 1'b0 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      if (init_busy !== 1'b0) begin
         err_total++;
         stop_test();
      end
   endtask
   initial begin
      srst = 1'b1;
      slow = 1'b1;
      partner_autoneg_capable = 1'b1;
      rx_polarity_reversed = 1'b0;
      err_total = 0;
      checked = 0;
      do_reset();
      wait_boot();
      chk(tag_value[0], {eb(8'h1b), eb(8'h1a)});
      chk(tag_value[1], {eb(8'h1d), eb(8'h1c)});
      chk(tag_value[2], {8'h00, eb(8'h1e)});
      chk(tag_value[3], {eb(8'h21), eb(8'h20)});
      rd(5'h00, 5'h1d, 16'h0980);
      chk(16'({jabber_en, heartbeat_en, repeater_mode}), 16'h0001);
      for (int p = 0; p < 4; p++) wr(5'h00, 5'h19 + 5'(p), 16'ha5c3 ^ 16'(p));
      for (int p = 0; p < 4; p++) begin
         chk(tag_value[p], 16'ha5c3 ^ 16'(p));
         rd(5'h00, 5'h19 + 5'(p), 16'ha5c3 ^ 16'(p));
      end
      rd(5'h00, 5'h18, 16'hffff);
      // Unknown op code must abort the frame and leave the tag alone
      ptpc_far_end_i.frame(2'h3, 5'h00, 5'h19, 16'h5555, v);
      chk(tag_value[0], 16'ha5c3);
      partner_autoneg_capable = 1'b0;
      rx_polarity_reversed = 1'b1;
      wr(5'h00, 5'h1d, 16'hffff);
      chk(16'({jabber_en, heartbeat_en, repeater_mode}), 16'h0007);
      rd(5'h1f, 5'h1d, 16'h0f7f);
      rd(5'h03, 5'h19, 16'hffff);
      wr(5'h03, 5'h19, 16'h1234);
      chk(tag_value[0], 16'ha5c3);
      wr(5'h1f, 5'h1d, 16'h0003);
      rd(5'h07, 5'h1d, 16'h0843);
      chk(16'({jabber_en, heartbeat_en, repeater_mode}), 16'h0000);
      ptpc_far_end_i.rom[1] = 8'h00;
      slow = 1'b0;
      do_reset();
      wait_boot();
      for (int p = 0; p < 4; p++) chk(tag_value[p], 16'h0000);
      rd(5'h00, 5'h1d, 16'h0940);
      stop_test();
   end
endmodule
